// ---- verif/tb_top.sv ----
// testbench of the test signal generator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk_sys, resetn, reg_wr, reg_rd, loop_take, take_en, busy_q;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, inj_value_q, lv0, lv1, namp, last_smp;
    logic        inj_flux_q, inj_torque_q, inj_speed_q, inj_pos_q, inj_ramp_q;
    logic [15:0] exp_rd[$];
    logic [15:0] exp_smp[$];
    logic        rd_prev = 1'b0, take_prev = 1'b0, noise = 1'b0;
    int          error_cnt = 0, total_checks = 0, nidx = 0, nflips = 0, t0, t1, rep;
    tsg_top DUT (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .loop_take(loop_take),
        .inj_value_q(inj_value_q), .inj_flux_q(inj_flux_q), .inj_torque_q(inj_torque_q),
        .inj_speed_q(inj_speed_q), .inj_pos_q(inj_pos_q), .inj_ramp_q(inj_ramp_q), .busy_q(busy_q));
    tsg_loop_model u_loop (.clk_sys(clk_sys), .resetn(resetn), .take_en(take_en), .loop_take(loop_take));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        exp_rd.push_back(e);
    endtask
    task automatic idle;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (rd_prev && exp_rd.size() > 0) chk(reg_rdata_q, exp_rd.pop_front());
        if (take_prev && exp_smp.size() > 0) chk(inj_value_q, exp_smp.pop_front());
        if (take_prev && noise && nidx < 60) begin
            if (nidx == 0) chk(inj_value_q, 16'h0000);
            else chk((inj_value_q === 16'(-namp)) ? namp : inj_value_q, namp);
            if (nidx > 2 && (nidx - 2) % 4 != 0) chk(inj_value_q, last_smp);
            if (nidx > 1 && inj_value_q !== last_smp) nflips++;
            last_smp = inj_value_q;
            nidx++;
        end
        rd_prev <= reg_rd;
        take_prev <= loop_take;
    end
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        error_cnt++;
        summarize;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        take_en = 1'b0;
        void'($urandom(32'h82409E0B));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(4'h0, 16'h0000);
        wr(4'h2, 16'h0003);
        wr(4'hC, 16'h0001);
        wr(4'hD, 16'h0002);
        wr(4'hF, 16'h1234);
        rd(4'h2, 16'h0003);
        rd(4'hC, 16'h0001);
        rd(4'hD, 16'h0002);
        rd(4'hF, 16'h0000);
        idle;
        for (int s = 0; s <= 5; s++) begin
            wr(4'h1, 16'(s));
            wr(4'h0, 16'h0002);
            rd(4'h0, 16'h0002);
            idle;
            repeat (2) @(posedge clk_sys);
            chk({11'h0, inj_ramp_q, inj_pos_q, inj_speed_q, inj_torque_q, inj_flux_q},
                (s == 0) ? 16'h0000 : 16'h0001 << (s - 1));
            wr(4'h0, 16'(s % 2));
            idle;
        end
        lv0 = 16'($urandom_range(16'h3FFF, 16'h0001));
        lv1 = 16'(-$urandom_range(16'h3FFF, 16'h0001));
        t0 = $urandom_range(6, 2);
        t1 = $urandom_range(6, 2);
        rep = $urandom_range(3, 2);
        wr(4'h3, lv0);
        wr(4'h4, lv1);
        wr(4'h5, 16'(t0));
        wr(4'h6, 16'(t1));
        wr(4'h2, 16'(rep));
        wr(4'h7, 16'h0000);
        wr(4'hB, 16'h0000);
        wr(4'h1, 16'h0003);
        exp_smp.push_back(16'h0000);
        for (int r = 0; r < rep; r++) begin
            repeat (t0) exp_smp.push_back(lv0);
            repeat (t1) exp_smp.push_back(lv1);
            repeat (2) exp_smp.push_back(16'h0000);
        end
        wr(4'h0, 16'h0002);
        idle;
        take_en <= 1'b1;
        for (int i = 0; i < 3000 && exp_smp.size() > 0; i++) @(posedge clk_sys);
        chk(16'(exp_smp.size()), 16'h0000);
        rd(4'hE, 16'(rep));
        idle;
        take_en <= 1'b0;
        wr(4'h0, 16'h0001);
        idle;
        rd(4'hE, 16'h0000);
        idle;
        namp = 16'($urandom_range(16'h0FFF, 16'h0100));
        wr(4'h3, 16'h0000);
        wr(4'h4, 16'h0000);
        wr(4'h5, 16'h0028);
        wr(4'h6, 16'h0028);
        wr(4'h2, 16'h0001);
        wr(4'hD, 16'h0000);
        wr(4'hA, 16'h0004);
        wr(4'hB, namp);
        noise = 1'b1;
        wr(4'h0, 16'h0002);
        idle;
        take_en <= 1'b1;
        for (int i = 0; i < 3000 && nidx < 60; i++) @(posedge clk_sys);
        chk(16'(nflips > 0), 16'h0001);
        take_en <= 1'b0;
        wr(4'h0, 16'h0000);
        idle;
        repeat (4) @(posedge clk_sys);
        summarize;
    end
endmodule
`default_nettype wire

// ---- verif/tsg_chk_sva.sv ----
// assertion checker of the test signal generator
`timescale 1ns/1ns
`default_nettype none
module tsg_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata_q,
    // injection
    input wire logic        loop_take,
    input wire logic [15:0] inj_value_q,
    input wire logic        inj_flux_q,
    input wire logic        inj_torque_q,
    input wire logic        inj_speed_q,
    input wire logic        inj_pos_q,
    input wire logic        inj_ramp_q,
    input wire logic        busy_q
);
    wire logic [4:0] tgt_w = {inj_ramp_q, inj_pos_q, inj_speed_q, inj_torque_q, inj_flux_q};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // run control writes
    // ----------------------------------------
    sequence go_s;
        reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h2;
    endsequence
    sequence stop_s;
        reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] != 2'h2;
    endsequence
    sequence sel_go_s;
        (reg_wr && reg_addr == 4'h1 && reg_wdata inside {[16'h0001:16'h0005]}) ##1 go_s;
    endsequence
    AST_GO_TGT: assert property (sel_go_s |-> ##2 tgt_w == 5'(5'h01 << ($past(reg_wdata[2:0], 3) - 3'h1)))
        else $error("target not raised after start");
    AST_STOP: assert property (stop_s |-> ##2 (tgt_w == 5'h00 && inj_value_q == 16'h0000))
        else $error("stop did not silence output");
    AST_RUN_RDBACK: assert property ((reg_wr && reg_addr == 4'h0) ##1 (reg_rd && reg_addr == 4'h0)
        |=> reg_rdata_q[1:0] == $past(reg_wdata[1:0], 2))
        else $error("run control readback wrong");
    AST_RD_ZERO: assert property (reg_rdata_q != 16'h0000 |-> $past(reg_rd))
        else $error("read data outside read slot");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata_q == 16'h0000)
        else $error("unmapped read not zero");
    AST_ONEHOT: assert property ($onehot0(tgt_w))
        else $error("several targets selected");
    AST_TGT_HOLD: assert property ($changed(tgt_w) |-> $past(reg_wr, 2))
        else $error("target changed without write");
    AST_INJ_TAKE: assert property (inj_value_q != 16'h0000 |-> $past(loop_take))
        else $error("sample without loop take");
    AST_QUIET: assert property ($rose(resetn) |-> (tgt_w == 5'h00 && !busy_q)[*2])
        else $error("outputs active after reset");
endmodule
bind tsg_top tsg_chk u_chk (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .loop_take, .inj_value_q, .inj_flux_q, .inj_torque_q, .inj_speed_q, .inj_pos_q, .inj_ramp_q, .busy_q);
`default_nettype wire

// ---- verif/tsg_loop_model.sv ----
// loop model that takes injected samples with random stalls
`timescale 1ns/1ns
`default_nettype none
module tsg_loop_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // control
    input  wire logic take_en,
    // loop side
    output logic      loop_take
);
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loop_take <= 1'b0;
        end else begin
            loop_take <= take_en && ($urandom_range(1, 0) == 1);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/tsg_fifo.sv ----
// fifo between sample former and loop outputs
`timescale 1ns/1ns
`default_nettype none
module tsg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // flush
    input  wire logic             flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              do_wr;
    wire              do_rd;
    wire              full;
    wire              empty;
    assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty     = (wp_q == rp_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rp_q[AW-1:0]];
    assign do_wr     = in_valid && !full;
    assign do_rd     = out_ready && !empty;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(do_wr);
            rp_q <= rp_q + (AW+1)'(do_rd);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/tsg_map.svh ----
// constants of the test signal generator
// How it works
// - run control: 0 off, 1 stopped, 2 running
// - selector routes output to one loop
// - sequence repeats repeat_count times
// - square wave has two stage levels
// - stage one lasts t1, stage two t2
// - sine with programmable amplitude and frequency
// - start phase sets initial waveform angle
// - noise updates once every ntime_q samples
// - noise toggles between plus and minus amplitude
// - noise comes from feedback shift register
// - shape setting picks sine or triangle
// - sine adds on top of square
// - injection independent of control mode
`ifndef TSG_MAP_SVH
`define TSG_MAP_SVH
`define TSG_ADDR_RUN      4'h0
`define TSG_ADDR_SEL      4'h1
`define TSG_ADDR_REPEAT   4'h2
`define TSG_ADDR_LEVEL0   4'h3
`define TSG_ADDR_LEVEL1   4'h4
`define TSG_ADDR_TIME0    4'h5
`define TSG_ADDR_TIME1    4'h6
`define TSG_ADDR_SAMP     4'h7
`define TSG_ADDR_SFREQ    4'h8
`define TSG_ADDR_PHASE    4'h9
`define TSG_ADDR_NTIME    4'hA
`define TSG_ADDR_NAMP     4'hB
`define TSG_ADDR_SHAPE    4'hC
`define TSG_ADDR_PAUSE    4'hD
`define TSG_ADDR_STATUS   4'hE
`define TSG_RUN_OFF       2'h0
`define TSG_RUN_STOP      2'h1
`define TSG_RUN_GO        2'h2
`define TSG_LFSR_SEED     15'h0001
`define TSG_FIFO_DEPTH    32
`endif

// ---- verilog/tsg_pkg.sv ----
// types of the test signal generator
`default_nettype none
package tsg_pkg;
    typedef enum logic [3:0] {
        TSG_IDLE  = 4'b0001,
        TSG_STG1  = 4'b0010,
        TSG_STG2  = 4'b0100,
        TSG_PAUSE = 4'b1000
    } tsg_state_t;
    typedef enum logic [2:0] {
        TSG_OUT_NONE  = 3'h0,
        TSG_OUT_FLUX  = 3'h1,
        TSG_OUT_TORQ  = 3'h2,
        TSG_OUT_SPEED = 3'h3,
        TSG_OUT_POS   = 3'h4,
        TSG_OUT_RAMP  = 3'h5
    } tsg_target_t;
endpackage
`default_nettype wire

// ---- verilog/tsg_top.sv ----
// test signal generator top
`include "tsg_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tsg_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata_q,
    // loop reference injection
    input  wire logic        loop_take,
    output logic [15:0]      inj_value_q,
    output logic             inj_flux_q,
    output logic             inj_torque_q,
    output logic             inj_speed_q,
    output logic             inj_pos_q,
    output logic             inj_ramp_q,
    output logic             busy_q
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rs1_q;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    logic [1:0]  run_q;
    logic [2:0]  sel_q;
    logic [15:0] repeat_q;
    logic [15:0] level0_q;
    logic [15:0] level1_q;
    logic [15:0] time0_q;
    logic [15:0] time1_q;
    logic [15:0] samp_q;
    logic [15:0] sfreq_q;
    logic [15:0] phase_q;
    logic [15:0] ntime_q;
    logic [15:0] namp_q;
    logic        shape_q;
    logic [15:0] pause_q;
    wire         wr_run;
    assign wr_run = reg_wr && (reg_addr == `TSG_ADDR_RUN);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_q    <= `TSG_RUN_OFF;
            sel_q    <= 3'h0;
            repeat_q <= 16'h0001;
            level0_q <= 16'h0000;
            level1_q <= 16'h0000;
            time0_q  <= 16'h0001;
            time1_q  <= 16'h0001;
            samp_q   <= 16'h0000;
            sfreq_q  <= 16'h0000;
            phase_q  <= 16'h0000;
            ntime_q  <= 16'h0001;
            namp_q   <= 16'h0000;
            shape_q  <= 1'b0;
            pause_q  <= 16'h0000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `TSG_ADDR_RUN:    run_q    <= reg_wdata[1:0];
                `TSG_ADDR_SEL:    sel_q    <= reg_wdata[2:0];
                `TSG_ADDR_REPEAT: repeat_q <= reg_wdata;
                `TSG_ADDR_LEVEL0: level0_q <= reg_wdata;
                `TSG_ADDR_LEVEL1: level1_q <= reg_wdata;
                `TSG_ADDR_TIME0:  time0_q  <= reg_wdata;
                `TSG_ADDR_TIME1:  time1_q  <= reg_wdata;
                `TSG_ADDR_SAMP:   samp_q   <= reg_wdata;
                `TSG_ADDR_SFREQ:  sfreq_q  <= reg_wdata;
                `TSG_ADDR_PHASE:  phase_q  <= reg_wdata;
                `TSG_ADDR_NTIME:  ntime_q  <= reg_wdata;
                `TSG_ADDR_NAMP:   namp_q   <= reg_wdata;
                `TSG_ADDR_SHAPE:  shape_q  <= reg_wdata[0];
                `TSG_ADDR_PAUSE:  pause_q  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    tsg_pkg::tsg_state_t st_q;
    tsg_pkg::tsg_state_t st_d;
    logic [15:0] tick_q;
    logic [15:0] cyc_q;
    logic [15:0] ph_q;
    logic [15:0] nt_q;
    logic [14:0] lfsr_q;
    wire         go;
    wire         step;
    wire         fifo_rdy;
    logic        tick_end;
    wire         last_cyc;
    assign go   = (run_q == `TSG_RUN_GO) && repeat_q != 16'h0000;
    assign step = go && fifo_rdy;
    assign last_cyc = (cyc_q + 16'h0001) >= repeat_q;
    always_comb begin
        unique case (st_q)
            tsg_pkg::TSG_STG1:  tick_end = (tick_q + 16'h0001) >= time0_q;
            tsg_pkg::TSG_STG2:  tick_end = (tick_q + 16'h0001) >= time1_q;
            tsg_pkg::TSG_PAUSE: tick_end = (tick_q + 16'h0001) >= pause_q;
            default:            tick_end = 1'b1;
        endcase
    end
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            tsg_pkg::TSG_IDLE:
                if (step && cyc_q == 16'h0000) st_d = tsg_pkg::TSG_STG1;
            tsg_pkg::TSG_STG1:
                if (step && tick_end) st_d = tsg_pkg::TSG_STG2;
            tsg_pkg::TSG_STG2: begin
                if (step && tick_end) begin
                    if (last_cyc) begin
                        st_d = tsg_pkg::TSG_IDLE;
                    end else if (pause_q != 16'h0000) begin
                        st_d = tsg_pkg::TSG_PAUSE;
                    end else begin
                        st_d = tsg_pkg::TSG_STG1;
                    end
                end
            end
            tsg_pkg::TSG_PAUSE:
                if (step && tick_end) st_d = tsg_pkg::TSG_STG1;
            default: st_d = tsg_pkg::TSG_IDLE;
        endcase
        if (!go) st_d = tsg_pkg::TSG_IDLE;
    end
    wire active;
    assign active = (st_q == tsg_pkg::TSG_STG1) || (st_q == tsg_pkg::TSG_STG2);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= tsg_pkg::TSG_IDLE;
            tick_q <= 16'h0000;
            cyc_q  <= 16'h0000;
            ph_q   <= 16'h0000;
            nt_q   <= 16'h0000;
            lfsr_q <= `TSG_LFSR_SEED;
        end else if (!go) begin
            st_q   <= tsg_pkg::TSG_IDLE;
            tick_q <= 16'h0000;
            cyc_q  <= 16'h0000;
            ph_q   <= phase_q;
            nt_q   <= 16'h0000;
        end else if (step) begin
            st_q   <= st_d;
            tick_q <= (st_d != st_q) ? 16'h0000 : tick_q + 16'h0001;
            if (st_q == tsg_pkg::TSG_STG2 && tick_end) cyc_q <= cyc_q + 16'h0001;
            if (active) begin
                ph_q <= ph_q + sfreq_q;
                nt_q <= ((nt_q + 16'h0001) >= ntime_q) ? 16'h0000 : nt_q + 16'h0001;
                if (nt_q == 16'h0000) begin
                    lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // waveform
    // ------------------------------------------------------------
    function automatic logic signed [15:0] tsg_scale(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [31:0] p;
        p = a * b;
        return p[30:15];
    endfunction
    wire signed [15:0] tri_w;
    wire signed [15:0] sin_w;
    wire signed [15:0] per_w;
    wire signed [15:0] sq_w;
    wire signed [15:0] nz_w;
    wire signed [15:0] sum_w;
    wire        [15:0] fold_w;
    assign fold_w = ph_q[14] ? ~{ph_q[13:0], 2'b00} : {ph_q[13:0], 2'b00};
    assign tri_w  = ph_q[15] ? -$signed({1'b0, fold_w[15:1]}) : $signed({1'b0, fold_w[15:1]});
    // cubic sine approximation
    assign sin_w  = tsg_scale(tri_w, 16'sh7FFF - tsg_scale(tri_w, tri_w) / 16'sd4) + tri_w / 16'sd4;
    assign per_w  = tsg_scale(shape_q ? tri_w : sin_w, $signed(samp_q));
    assign sq_w   = (st_q == tsg_pkg::TSG_STG1) ? $signed(level0_q) : $signed(level1_q);
    assign nz_w   = lfsr_q[0] ? $signed(namp_q) : -$signed(namp_q);
    assign sum_w  = active ? sq_w + per_w + nz_w : 16'sh0000;

    wire        fo_valid;
    wire [15:0] fo_data;
    tsg_fifo #(.WIDTH(16), .DEPTH(`TSG_FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (go),
        .in_ready  (fifo_rdy),
        .in_data   (sum_w),
        .out_valid (fo_valid),
        .out_ready (loop_take),
        .out_data  (fo_data),
        .flush     (!go)
    );

    // ------------------------------------------------------------
    // outputs and read back
    // ------------------------------------------------------------
    wire        emit;
    wire [15:0] rd_mux;
    assign emit = go && fo_valid && loop_take;
    assign rd_mux = (reg_addr == `TSG_ADDR_RUN)    ? {14'h0000, run_q} :
                    (reg_addr == `TSG_ADDR_SEL)    ? {13'h0000, sel_q} :
                    (reg_addr == `TSG_ADDR_REPEAT) ? repeat_q :
                    (reg_addr == `TSG_ADDR_STATUS) ? cyc_q :
                    (reg_addr == `TSG_ADDR_SHAPE)  ? {15'h0000, shape_q} :
                    (reg_addr == `TSG_ADDR_PAUSE)  ? pause_q : 16'h0000;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= 16'h0000;
            inj_value_q  <= 16'h0000;
            inj_flux_q   <= 1'b0;
            inj_torque_q <= 1'b0;
            inj_speed_q  <= 1'b0;
            inj_pos_q    <= 1'b0;
            inj_ramp_q   <= 1'b0;
            busy_q       <= 1'b0;
        end else begin
            reg_rdata_q  <= reg_rd ? rd_mux : 16'h0000;
            inj_value_q  <= emit ? fo_data : 16'h0000;
            inj_flux_q   <= go && sel_q == tsg_pkg::TSG_OUT_FLUX;
            inj_torque_q <= go && sel_q == tsg_pkg::TSG_OUT_TORQ;
            inj_speed_q  <= go && sel_q == tsg_pkg::TSG_OUT_SPEED;
            inj_pos_q    <= go && sel_q == tsg_pkg::TSG_OUT_POS;
            inj_ramp_q   <= go && sel_q == tsg_pkg::TSG_OUT_RAMP;
            busy_q       <= st_q != tsg_pkg::TSG_IDLE;
        end
    end
    wire unused_ok;
    assign unused_ok = wr_run;
endmodule
`default_nettype wire
